// [hw/rtc_pkg.sv]
// Constants, field layouts and carrier types for the real-time clock support block
package rtc_pkg;
   // Register offsets on the special function register port
   localparam logic [7:0] ADDR_UNLOCK_KEY  = 8'h90;
   localparam logic [7:0] ADDR_WAKEUP      = 8'h96;
   localparam logic [7:0] ADDR_WRITE_GUARD = 8'h97;
   localparam logic [7:0] ADDR_SNAPSHOT    = 8'hDA;
   localparam logic [7:0] ADDR_CNT_STATE   = 8'hDE;
   localparam logic [7:0] ADDR_CALIB       = 8'hE1;
   localparam logic [7:0] ADDR_SECONDS     = 8'hE2;
   localparam logic [7:0] ADDR_MINUTES     = 8'hE3;
   localparam logic [7:0] ADDR_HOURS       = 8'hE4;
   localparam logic [7:0] ADDR_PRESET_LOW  = 8'hE5;
   localparam logic [7:0] ADDR_PRESET_MID  = 8'hE6;
   localparam logic [7:0] ADDR_PRESET_HIGH = 8'hE7;
   // Key and guard values
   localparam logic [7:0] KEY_VALUE        = 8'h96;
   localparam logic [7:0] GUARD_ENABLE     = 8'h57;
   localparam logic [7:0] GUARD_DISABLE    = 8'h56;
   // Counter state register values
   localparam logic [7:0] CNT_VAL_DIVIDE   = 8'h00;
   localparam logic [7:0] CNT_VAL_WAIT     = 8'h01;
   localparam logic [7:0] CNT_VAL_MEASURE  = 8'h02;
   localparam logic [7:0] CNT_VAL_DONE     = 8'h03;
   // Protected register indices
   localparam int         PROT_COUNT       = 5;
   localparam int         IDX_WAKEUP       = 0;
   localparam int         IDX_CALIB        = 1;
   localparam int         IDX_SECONDS      = 2;
   localparam int         IDX_MINUTES      = 3;
   localparam int         IDX_HOURS        = 4;
   // Wakeup interval field: bit7 enable, bits 6:0 code
   localparam int         WAKE_EN_BIT      = 7;
   localparam logic [6:0] WAKE_CODE_500MS  = 7'h40;
   localparam logic [6:0] WAKE_CODE_250MS  = 7'h41;
   localparam logic [6:0] WAKE_CODE_125MS  = 7'h42;
   localparam logic [6:0] WAKE_CODE_62MS   = 7'h43;
   localparam logic [6:0] WAKE_CODE_MINUTE = 7'h44;
   localparam logic [6:0] WAKE_CODE_HOUR   = 7'h45;
   localparam logic [6:0] WAKE_CODE_DAY    = 7'h46;
   localparam logic [7:0] WAKEUP_RESET     = 8'h00;
   // Timing counts in oscillator cycles, preset reset value and BCD limits
   localparam logic [2:0] SETTLE_OSC       = 3'h5;
   localparam logic [3:0] WAKE_HOLD_OSC    = 4'h8;
   localparam logic [14:0] OSC_PER_SEC_M1  = 15'h7FFF;
   localparam logic [23:0] PRESET_RESET    = 24'h00_0000;
   localparam logic [7:0] BCD_59           = 8'h59;
   localparam logic [7:0] BCD_23           = 8'h23;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } sfr_req_t;

   typedef struct packed {
      logic global_irq_enable;
      logic ext_bit1;
      logic ext_bit2;
      logic ext_int3_bit6;
      logic ext_int4_bit0;
   } irq_enable_t;

   typedef enum logic [3:0] {
      CNT_DIVIDE  = 4'b0001,
      CNT_WAIT    = 4'b0010,
      CNT_MEASURE = 4'b0100,
      CNT_DONE    = 4'b1000
   } cnt_state_t;
endpackage : rtc_pkg

// [hw/rtc_access_and_pll_counter.sv]
// Real-time clock access guard, timekeeping, wakeup, interrupts and 24-bit divider counter
//
// Function
// - Clock runs in sleep and wakes at day, hour, minute, 1-64 s or sub-second intervals.
// - Each wakeup stays asserted eight oscillator periods.
// - Calibration and time survive every reset; other registers return to defaults.
// - Relock is 0x96 then 0x56; new contents take effect five oscillator cycles later.
// - Reading snapshot trigger latches time after five oscillator cycles; host waits that long.
// - Calibration register reads directly, no snapshot needed.
// - Clock runs from power-up, from random time unless time was preset.
// - Protected write while locked raises illegal-data interrupt when enabled.
// - Invalid-format write while unlocked raises illegal-data interrupt when enabled.
// - Time held in BCD; digit 0xF is not flagged illegal.
// - Rejected or malformed protected writes leave stored contents unchanged.
// - With all three enables set, one-second pulses raise a per-second interrupt.
// - 24-bit counter works as divider or measurer per state register.
// - State 0x00: count up, clear at preset, toggle output, restart.
// - Preset resets to zero; output is clock over two times (preset plus one).
// - State 0x01 waits; first reference rising edge moves to 0x02, counting from zero.
// - Second reference rising edge moves to 0x03, stops, copies count into preset.
// - Key accepts only 0x96; key and guard writes must be consecutive.
// - Guard accepts only 0x57 and 0x56; bit0 reads write-enable state.
`timescale 1ns/1ps
module rtc_access_and_pll_counter
   import rtc_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        nrst,
   input  wire logic        ce,
   input  wire sfr_req_t    sfr_req,
   output logic [7:0]       sfr_rdata,
   input  wire logic        osc_clk_pin,
   input  wire logic        reference_pulse_input,
   input  wire irq_enable_t irq_en,
   input  wire logic        ack_illegal,
   input  wire logic        ack_second,
   output logic             irq_illegal,
   output logic             irq_second,
   output logic             wakeup,
   output logic             div_out
);

   // Input synchronisers
   logic osc_s1_r, osc_s2_r, osc_s3_r;
   logic ref_s1_r, ref_s2_r, ref_s3_r;
   logic osc_tick;
   logic ref_rise;

   always_ff @(posedge clock) begin
      if (ce) begin
         osc_s1_r <= osc_clk_pin;
         osc_s2_r <= osc_s1_r;
         osc_s3_r <= osc_s2_r;
         ref_s1_r <= reference_pulse_input;
         ref_s2_r <= ref_s1_r;
         ref_s3_r <= ref_s2_r;
      end
   end

   assign osc_tick = osc_s2_r & ~osc_s3_r;
   assign ref_rise = ref_s2_r & ~ref_s3_r;

   // Register port decode
   logic wr_key, wr_guard, wr_state, rd_snap;
   logic [PROT_COUNT-1:0] wr_prot;

   assign wr_key   = sfr_req.wr && sfr_req.addr == ADDR_UNLOCK_KEY;
   assign wr_guard = sfr_req.wr && sfr_req.addr == ADDR_WRITE_GUARD;
   assign wr_state = sfr_req.wr && sfr_req.addr == ADDR_CNT_STATE;
   assign rd_snap  = sfr_req.rd && sfr_req.addr == ADDR_SNAPSHOT;
   assign wr_prot[IDX_WAKEUP]  = sfr_req.wr && sfr_req.addr == ADDR_WAKEUP;
   assign wr_prot[IDX_CALIB]   = sfr_req.wr && sfr_req.addr == ADDR_CALIB;
   assign wr_prot[IDX_SECONDS] = sfr_req.wr && sfr_req.addr == ADDR_SECONDS;
   assign wr_prot[IDX_MINUTES] = sfr_req.wr && sfr_req.addr == ADDR_MINUTES;
   assign wr_prot[IDX_HOURS]   = sfr_req.wr && sfr_req.addr == ADDR_HOURS;

   // Unlock key and write guard
   logic       key_armed_r;
   logic       write_en_r;
   logic       relock;
   logic [2:0] act_cnt_r;
   logic       commit;

   assign relock = wr_guard && key_armed_r && sfr_req.wdata == GUARD_DISABLE;

   always_ff @(posedge clock) begin
      if (!nrst) begin
         key_armed_r <= 1'b0;
      end else if (ce && sfr_req.wr) begin
         key_armed_r <= wr_key && sfr_req.wdata == KEY_VALUE;
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         write_en_r <= 1'b0;
      end else if (ce && wr_guard && key_armed_r) begin
         if (sfr_req.wdata == GUARD_ENABLE) begin
            write_en_r <= 1'b1;
         end else if (sfr_req.wdata == GUARD_DISABLE) begin
            write_en_r <= 1'b0;
         end
      end
   end

   // Activation countdown after relock
   always_ff @(posedge clock) begin
      if (!nrst) begin
         act_cnt_r <= 3'h0;
      end else if (ce) begin
         if (relock) begin
            act_cnt_r <= SETTLE_OSC;
         end else if (osc_tick && act_cnt_r != 3'h0) begin
            act_cnt_r <= act_cnt_r - 3'h1;
         end
      end
   end

   assign commit = osc_tick && act_cnt_r == 3'h1;

   // Format check for protected contents
   function automatic logic legal_value(input int idx, input logic [7:0] d);
      logic bad_hi, bad_lo;
      bad_hi = d[7:4] > 4'h9 && d[7:4] != 4'hF;
      bad_lo = d[3:0] > 4'h9 && d[3:0] != 4'hF;
      if (idx == IDX_WAKEUP) begin
         legal_value = d[6:0] <= WAKE_CODE_DAY;
      end else if (idx == IDX_CALIB) begin
         legal_value = 1'b1;
      end else begin
         legal_value = !(bad_hi || bad_lo);
      end
   endfunction : legal_value

   // BCD increment with wrap; carry set on wrap
   function automatic logic [8:0] bcd_inc(input logic [7:0] v, input logic [7:0] top);
      logic [7:0] n;
      n = v;
      if (v == top) begin
         bcd_inc = {1'b1, 8'h00};
      end else begin
         if (v[3:0] >= 4'h9) begin
            n[3:0] = 4'h0;
            n[7:4] = v[7:4] + 4'h1;
         end else begin
            n[3:0] = v[3:0] + 4'h1;
         end
         bcd_inc = {1'b0, n};
      end
   endfunction : bcd_inc

   // Oscillator prescaler and one-second pulse
   logic [14:0] sub_r;
   logic        sec_pulse;

   // Only the fraction of a second restarts on reset; the time registers keep counting from their contents
   always_ff @(posedge clock) begin
      if (!nrst) begin
         sub_r <= 15'h0000;
      end else if (ce && osc_tick) begin
         sub_r <= (sub_r == OSC_PER_SEC_M1) ? 15'h0000 : sub_r + 15'h0001;
      end
   end

   assign sec_pulse = osc_tick && sub_r == OSC_PER_SEC_M1;

   // Time advance
   logic [7:0] live_r [PROT_COUNT];
   logic [7:0] shadow_r [PROT_COUNT];
   logic [PROT_COUNT-1:0] dirty_r;
   logic [8:0] sec_inc, min_inc, hour_inc;
   logic [7:0] time_nxt [PROT_COUNT];
   logic       min_roll, hour_roll, day_roll;

   assign sec_inc   = bcd_inc(live_r[IDX_SECONDS], BCD_59);
   assign min_inc   = bcd_inc(live_r[IDX_MINUTES], BCD_59);
   assign hour_inc  = bcd_inc(live_r[IDX_HOURS], BCD_23);
   assign min_roll  = sec_pulse && sec_inc[8];
   assign hour_roll = min_roll && min_inc[8];
   assign day_roll  = hour_roll && hour_inc[8];

   always_comb begin
      time_nxt[IDX_WAKEUP]  = live_r[IDX_WAKEUP];
      time_nxt[IDX_CALIB]   = live_r[IDX_CALIB];
      time_nxt[IDX_SECONDS] = sec_pulse ? sec_inc[7:0] : live_r[IDX_SECONDS];
      time_nxt[IDX_MINUTES] = min_roll ? min_inc[7:0] : live_r[IDX_MINUTES];
      time_nxt[IDX_HOURS]   = hour_roll ? hour_inc[7:0] : live_r[IDX_HOURS];
   end

   // Protected registers: shadow on write, live after activation
   logic [PROT_COUNT-1:0] bad_write;

   genvar gi;
   generate
      for (gi = 0; gi < PROT_COUNT; gi++) begin : g_prot
         logic accept;
         assign accept       = wr_prot[gi] && write_en_r && legal_value(gi, sfr_req.wdata);
         assign bad_write[gi] = wr_prot[gi] && !accept;

         always_ff @(posedge clock) begin
            if (ce && accept) begin
               shadow_r[gi] <= sfr_req.wdata;
            end
         end

         always_ff @(posedge clock) begin
            if (!nrst) begin
               dirty_r[gi] <= 1'b0;
            end else if (ce) begin
               if (accept) begin
                  dirty_r[gi] <= 1'b1;
               end else if (commit) begin
                  dirty_r[gi] <= 1'b0;
               end
            end
         end

         if (gi == IDX_WAKEUP) begin : g_reset
            always_ff @(posedge clock) begin
               if (!nrst) begin
                  live_r[gi] <= WAKEUP_RESET;
               end else if (ce && commit && dirty_r[gi]) begin
                  live_r[gi] <= shadow_r[gi];
               end
            end
         end else begin : g_keep
            always_ff @(posedge clock) begin
               if (ce) begin
                  if (commit && dirty_r[gi]) begin
                     live_r[gi] <= shadow_r[gi];
                  end else begin
                     live_r[gi] <= time_nxt[gi];
                  end
               end
            end
         end
      end
   endgenerate

   // Snapshot latch of time
   logic [2:0] snap_cnt_r;
   logic [7:0] snap_r [3];

   always_ff @(posedge clock) begin
      if (!nrst) begin
         snap_cnt_r <= 3'h0;
      end else if (ce) begin
         if (rd_snap) begin
            snap_cnt_r <= SETTLE_OSC;
         end else if (osc_tick && snap_cnt_r != 3'h0) begin
            snap_cnt_r <= snap_cnt_r - 3'h1;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         snap_r[0] <= 8'h00;
         snap_r[1] <= 8'h00;
         snap_r[2] <= 8'h00;
      end else if (ce && osc_tick && snap_cnt_r == 3'h1) begin
         snap_r[0] <= live_r[IDX_SECONDS];
         snap_r[1] <= live_r[IDX_MINUTES];
         snap_r[2] <= live_r[IDX_HOURS];
      end
   end

   // Wakeup interval and hold
   logic [5:0] wake_sec_r;
   logic [6:0] wcode;
   logic       wake_event;
   logic [3:0] wake_cnt_r;

   assign wcode = live_r[IDX_WAKEUP][6:0];

   always_comb begin
      wake_event = 1'b0;
      if (wcode < WAKE_CODE_500MS) begin
         wake_event = sec_pulse && wake_sec_r == wcode[5:0];
      end else if (wcode == WAKE_CODE_500MS) begin
         wake_event = osc_tick && sub_r[13:0] == OSC_PER_SEC_M1[13:0];
      end else if (wcode == WAKE_CODE_250MS) begin
         wake_event = osc_tick && sub_r[12:0] == OSC_PER_SEC_M1[12:0];
      end else if (wcode == WAKE_CODE_125MS) begin
         wake_event = osc_tick && sub_r[11:0] == OSC_PER_SEC_M1[11:0];
      end else if (wcode == WAKE_CODE_62MS) begin
         wake_event = osc_tick && sub_r[10:0] == OSC_PER_SEC_M1[10:0];
      end else if (wcode == WAKE_CODE_MINUTE) begin
         wake_event = min_roll;
      end else if (wcode == WAKE_CODE_HOUR) begin
         wake_event = hour_roll;
      end else if (wcode == WAKE_CODE_DAY) begin
         wake_event = day_roll;
      end
      wake_event = wake_event && live_r[IDX_WAKEUP][WAKE_EN_BIT];
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         wake_sec_r <= 6'h00;
      end else if (ce && sec_pulse) begin
         wake_sec_r <= (wake_sec_r == wcode[5:0]) ? 6'h00 : wake_sec_r + 6'h01;
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         wake_cnt_r <= 4'h0;
      end else if (ce) begin
         if (wake_event) begin
            wake_cnt_r <= WAKE_HOLD_OSC;
         end else if (osc_tick && wake_cnt_r != 4'h0) begin
            wake_cnt_r <= wake_cnt_r - 4'h1;
         end
      end
   end

   assign wakeup = wake_cnt_r != 4'h0;

   // Interrupt pending flags; a set wins over an acknowledge
   logic ill_en, sec_en;

   assign ill_en = irq_en.global_irq_enable && irq_en.ext_bit2 && irq_en.ext_int4_bit0;
   assign sec_en = irq_en.global_irq_enable && irq_en.ext_bit1 && irq_en.ext_int3_bit6;

   always_ff @(posedge clock) begin
      if (!nrst) begin
         irq_illegal <= 1'b0;
      end else if (ce) begin
         if (ill_en && |bad_write) begin
            irq_illegal <= 1'b1;
         end else if (ack_illegal) begin
            irq_illegal <= 1'b0;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         irq_second <= 1'b0;
      end else if (ce) begin
         if (sec_en && sec_pulse) begin
            irq_second <= 1'b1;
         end else if (ack_second) begin
            irq_second <= 1'b0;
         end
      end
   end

   // Divider and measurement counter
   cnt_state_t  cnt_state_r;
   logic [23:0] count_r;
   logic [23:0] preset_r;

   always_ff @(posedge clock) begin
      if (!nrst) begin
         cnt_state_r <= CNT_DIVIDE;
      end else if (ce) begin
         if (wr_state && sfr_req.wdata == CNT_VAL_DIVIDE) begin
            cnt_state_r <= CNT_DIVIDE;
         end else if (wr_state && sfr_req.wdata == CNT_VAL_WAIT) begin
            cnt_state_r <= CNT_WAIT;
         end else begin
            case (cnt_state_r)
               CNT_WAIT: if (ref_rise) cnt_state_r <= CNT_MEASURE;
               CNT_MEASURE: if (ref_rise) cnt_state_r <= CNT_DONE;
               default: cnt_state_r <= cnt_state_r;
            endcase
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         count_r <= 24'h00_0000;
      end else if (ce) begin
         if (wr_state) begin
            count_r <= 24'h00_0000;
         end else begin
            case (cnt_state_r)
               CNT_DIVIDE: count_r <= (count_r == preset_r) ? 24'h00_0000 : count_r + 24'h00_0001;
               CNT_WAIT: count_r <= 24'h00_0000;
               CNT_MEASURE: count_r <= count_r + 24'h00_0001;
               default: count_r <= count_r;
            endcase
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         div_out <= 1'b0;
      end else if (ce && cnt_state_r == CNT_DIVIDE && count_r == preset_r) begin
         div_out <= ~div_out;
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         preset_r <= PRESET_RESET;
      end else if (ce) begin
         if (cnt_state_r == CNT_MEASURE && ref_rise && !wr_state) begin
            preset_r <= count_r;
         end else if (sfr_req.wr && sfr_req.addr == ADDR_PRESET_LOW) begin
            preset_r[7:0] <= sfr_req.wdata;
         end else if (sfr_req.wr && sfr_req.addr == ADDR_PRESET_MID) begin
            preset_r[15:8] <= sfr_req.wdata;
         end else if (sfr_req.wr && sfr_req.addr == ADDR_PRESET_HIGH) begin
            preset_r[23:16] <= sfr_req.wdata;
         end
      end
   end

   // Read data
   logic [7:0] rd_mux;

   always_comb begin
      case (sfr_req.addr)
         ADDR_WRITE_GUARD: rd_mux = {7'h00, write_en_r};
         ADDR_WAKEUP:      rd_mux = live_r[IDX_WAKEUP];
         ADDR_CALIB:       rd_mux = live_r[IDX_CALIB];
         ADDR_SECONDS:     rd_mux = snap_r[0];
         ADDR_MINUTES:     rd_mux = snap_r[1];
         ADDR_HOURS:       rd_mux = snap_r[2];
         ADDR_PRESET_LOW:  rd_mux = preset_r[7:0];
         ADDR_PRESET_MID:  rd_mux = preset_r[15:8];
         ADDR_PRESET_HIGH: rd_mux = preset_r[23:16];
         ADDR_CNT_STATE: begin
            case (cnt_state_r)
               CNT_WAIT:    rd_mux = CNT_VAL_WAIT;
               CNT_MEASURE: rd_mux = CNT_VAL_MEASURE;
               CNT_DONE:    rd_mux = CNT_VAL_DONE;
               default:     rd_mux = CNT_VAL_DIVIDE;
            endcase
         end
         default:          rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         sfr_rdata <= 8'h00;
      end else if (ce && sfr_req.rd) begin
         sfr_rdata <= rd_mux;
      end
   end

endmodule : rtc_access_and_pll_counter

// [verif/rtc_access_and_pll_counter_assertions.sv]
// Port assertions for the real-time clock support block
`timescale 1ns/1ps
module rtc_chk
   import rtc_pkg::*;
(
   input wire logic        clock,
   input wire logic        nrst,
   input wire logic        ce,
   input wire sfr_req_t    sfr_req,
   input wire logic [7:0]  sfr_rdata,
   input wire irq_enable_t irq_en,
   input wire logic        ack_illegal,
   input wire logic        irq_illegal,
   input wire logic        irq_second,
   input wire logic        wakeup
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);
   sequence s_wr(logic [7:0] a, logic [7:0] d); ce && sfr_req.wr && sfr_req.addr == a && sfr_req.wdata == d; endsequence
   sequence s_rd(logic [7:0] a); ce && sfr_req.rd && sfr_req.addr == a; endsequence
   sequence s_key; s_wr(ADDR_UNLOCK_KEY, KEY_VALUE); endsequence
   sequence s_wake; $rose(wakeup); endsequence
   property p_guard_on;
      s_key ##1 s_wr(ADDR_WRITE_GUARD, GUARD_ENABLE) ##1 s_rd(ADDR_WRITE_GUARD) |=> sfr_rdata == 8'h01;
   endproperty
   a_guard_on: assert property (p_guard_on) else $error("guard not set");
   property p_guard_off;
      s_key ##1 s_wr(ADDR_WRITE_GUARD, GUARD_DISABLE) ##1 s_rd(ADDR_WRITE_GUARD) |=> sfr_rdata == 8'h00;
   endproperty
   a_guard_off: assert property (p_guard_off) else $error("guard not cleared");
   property p_key_read; s_rd(ADDR_UNLOCK_KEY) |=> sfr_rdata == 8'h00; endproperty
   a_key_read: assert property (p_key_read) else $error("key readable");
   property p_wait_read; s_wr(ADDR_CNT_STATE, CNT_VAL_WAIT) ##1 s_rd(ADDR_CNT_STATE) |=> sfr_rdata == CNT_VAL_WAIT; endproperty
   a_wait_read: assert property (p_wait_read) else $error("wait state lost");
   property p_sticky; irq_illegal && !ack_illegal |=> irq_illegal; endproperty
   a_sticky: assert property (p_sticky) else $error("flag dropped");
   property p_irq_cause;
      $rose(irq_illegal) |-> $past(ce && sfr_req.wr && irq_en.global_irq_enable && irq_en.ext_bit2 && irq_en.ext_int4_bit0);
   endproperty
   a_irq_cause: assert property (p_irq_cause) else $error("flag without cause");
   property p_sec_quiet;
      !irq_second && !(irq_en.global_irq_enable && irq_en.ext_bit1 && irq_en.ext_int3_bit6) |=> !irq_second;
   endproperty
   a_sec_quiet: assert property (p_sec_quiet) else $error("second flag while disabled");
   property p_wake_hold; s_wake |-> wakeup [*8] ##[1:1000] !wakeup; endproperty
   a_wake_hold: assert property (p_wake_hold) else $error("wake pulse length");
endmodule : rtc_chk

bind rtc_access_and_pll_counter rtc_chk u_rtc_chk (.clock(clock), .nrst(nrst), .ce(ce), .sfr_req(sfr_req),
   .sfr_rdata(sfr_rdata), .irq_en(irq_en), .ack_illegal(ack_illegal), .irq_illegal(irq_illegal),
   .irq_second(irq_second), .wakeup(wakeup));

// [verif/mcu_host.sv]
// Host core model driving the special function register port
`timescale 1ns/1ps
module mcu_host
   import rtc_pkg::*;
(
   input  wire logic clock,
   input  wire logic osc_clk_pin,
   output sfr_req_t  sfr_req
);
   initial sfr_req = '0;
   task automatic drive(input sfr_req_t r);
      @(posedge clock);
      sfr_req <= r;
   endtask : drive
   // Idles the port, then lets n oscillator ticks pass
   task automatic ticks(input int n);
      @(posedge clock);
      sfr_req <= '0;
      repeat (n) @(posedge osc_clk_pin);
   endtask : ticks
   task automatic guard(input logic [7:0] g);
      drive('{1'b1, 1'b0, ADDR_UNLOCK_KEY, KEY_VALUE});
      drive('{1'b1, 1'b0, ADDR_WRITE_GUARD, g});
   endtask : guard
endmodule : mcu_host

// [verif/tb_rtc_access_and_pll_counter.sv]
// Self-checking bench for the real-time clock support block
`timescale 1ns/1ps
module tb_rtc_access_and_pll_counter
   import rtc_pkg::*;
();
   logic        clock = 1'b0;
   logic        nrst = 1'b0;
   logic        ce = 1'b1;
   logic        osc_clk_pin = 1'b0;
   logic        reference_pulse_input = 1'b0;
   irq_enable_t irq_en = '0;
   logic        ack_illegal = 1'b0;
   logic        ack_second = 1'b0;
   sfr_req_t    sfr_req;
   logic [7:0]  sfr_rdata, rd_val;
   logic        irq_illegal, irq_second, wakeup, div_out, b;
   logic        rd_d = 1'b0;
   logic [8:0]  exp_q[$];
   logic [8:0]  ent;
   logic [15:0] n, p, c;
   int          mismatches = 0;
   int          n_checks = 0;
   int          cyc = 0;

   always #5 clock = ~clock;
   // Fast oscillator: one tick every two clocks
   always @(posedge clock) osc_clk_pin <= ~osc_clk_pin;

   mcu_host host (.clock(clock), .osc_clk_pin(osc_clk_pin), .sfr_req(sfr_req));
   rtc_access_and_pll_counter DUT (.clock(clock), .nrst(nrst), .ce(ce), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
      .osc_clk_pin(osc_clk_pin), .reference_pulse_input(reference_pulse_input), .irq_en(irq_en),
      .ack_illegal(ack_illegal), .ack_second(ack_second), .irq_illegal(irq_illegal), .irq_second(irq_second),
      .wakeup(wakeup), .div_out(div_out));

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : tally_and_finish
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      host.drive('{1'b1, 1'b0, a, d});
   endtask : wr
   // Notes the expected read value; k low means the value is not compared
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic k = 1'b1);
      exp_q.push_back({k, e});
      host.drive('{1'b0, 1'b1, a, 8'h00});
   endtask : rd
   task automatic ack_irq(input logic e);
      host.ticks(1);
      check(16'(irq_illegal), 16'(e));
      @(posedge clock) {ack_illegal, ack_second} <= 2'h3;
      @(posedge clock) {ack_illegal, ack_second} <= 2'h0;
      @(posedge clock) check(16'(irq_second), 16'd0);
   endtask : ack_irq
   task automatic until_wake(input logic v, output logic [15:0] k);
      k = 0;
      while (wakeup !== v && k < 16'd9000) begin
         @(posedge clock);
         k++;
      end
   endtask : until_wake

   always @(posedge clock) begin
      if (rd_d) begin
         ent = exp_q.pop_front();
         rd_val = sfr_rdata;
         if (ent[8]) check(16'(sfr_rdata), 16'(ent[7:0]));
      end
      rd_d <= ce & sfr_req.rd;
      cyc++;
      if (cyc == 90000) begin
         mismatches++;
         tally_and_finish();
      end
   end

   initial begin
      void'($urandom(32'h7ad5));
      repeat (6) @(posedge clock);
      nrst <= 1'b1;
      rd(ADDR_CNT_STATE, CNT_VAL_DIVIDE);
      rd(ADDR_WRITE_GUARD, 8'h00);
      rd(ADDR_UNLOCK_KEY, 8'h00);
      rd(8'h55, 8'h00);
      rd(ADDR_PRESET_LOW, PRESET_RESET[7:0]);
      p = 16'($urandom_range(6, 1));
      wr(ADDR_PRESET_LOW, p[7:0]);
      wr(ADDR_CNT_STATE, CNT_VAL_DIVIDE);
      host.ticks(2);
      repeat (2) begin
         n = 1;
         @(posedge clock);
         b = div_out;
         while (div_out === b && n < 64) begin
            @(posedge clock);
            n++;
         end
      end
      check(n, p + 16'd1);
      irq_en <= '1;
      c = 16'($urandom_range(255, 0));
      host.guard(GUARD_ENABLE);
      rd(ADDR_WRITE_GUARD, 8'h01);
      host.ticks(6);
      wr(ADDR_SECONDS, 8'h0F);
      wr(ADDR_MINUTES, 8'h30);
      wr(ADDR_HOURS, 8'h12);
      wr(ADDR_CALIB, c[7:0]);
      wr(ADDR_WAKEUP, {1'b1, WAKE_CODE_62MS});
      ack_irq(1'b0);
      wr(ADDR_MINUTES, 8'h3A);
      ack_irq(1'b1);
      host.ticks(6);
      host.guard(GUARD_DISABLE);
      rd(ADDR_WRITE_GUARD, 8'h00);
      host.ticks(7);
      rd(ADDR_CALIB, c[7:0]);
      rd(ADDR_WAKEUP, {1'b1, WAKE_CODE_62MS});
      rd(ADDR_SNAPSHOT, 8'h00, 1'b0);
      host.ticks(6);
      rd(ADDR_SECONDS, 8'h0F);
      rd(ADDR_MINUTES, 8'h30);
      wr(ADDR_SECONDS, 8'h22);
      ack_irq(1'b1);
      irq_en.global_irq_enable <= 1'b0;
      wr(ADDR_SECONDS, 8'h33);
      ack_irq(1'b0);
      rd(ADDR_SNAPSHOT, 8'h00, 1'b0);
      host.ticks(6);
      rd(ADDR_SECONDS, 8'h0F);
      host.ticks(1);
      until_wake(1'b0, n);
      until_wake(1'b1, n);
      until_wake(1'b0, n);
      check(n, 16'd16);
      until_wake(1'b1, p);
      check(n + p, 16'd4096);
      wr(ADDR_CNT_STATE, CNT_VAL_WAIT);
      rd(ADDR_CNT_STATE, CNT_VAL_WAIT);
      fork
         begin
            @(posedge clock) reference_pulse_input <= 1'b1;
            repeat (100) @(posedge clock);
            reference_pulse_input <= 1'b0;
            repeat (100) @(posedge clock);
            reference_pulse_input <= 1'b1;
         end
      join_none
      host.ticks(20);
      rd(ADDR_CNT_STATE, CNT_VAL_MEASURE);
      host.ticks(100);
      rd(ADDR_CNT_STATE, CNT_VAL_DONE);
      rd(ADDR_PRESET_MID, 8'h00);
      rd(ADDR_PRESET_LOW, 8'h00, 1'b0);
      host.ticks(2);
      check(16'(rd_val - 8'd199 <= 8'd2), 16'd1);
      @(posedge clock) nrst <= 1'b0;
      repeat (2) @(posedge clock);
      nrst <= 1'b1;
      rd(ADDR_CALIB, c[7:0]);
      rd(ADDR_WAKEUP, WAKEUP_RESET);
      rd(ADDR_CNT_STATE, CNT_VAL_DIVIDE);
      host.ticks(1);
      ce <= 1'b0;
      wr(ADDR_PRESET_LOW, 8'h5A);
      host.ticks(1);
      ce <= 1'b1;
      rd(ADDR_PRESET_LOW, PRESET_RESET[7:0]);
      irq_en <= '1;
      host.ticks(32772);
      check(16'(irq_second), 16'd1);
      ack_irq(1'b0);
      rd(ADDR_SNAPSHOT, 8'h00, 1'b0);
      host.ticks(6);
      rd(ADDR_SECONDS, 8'h10);
      rd(ADDR_HOURS, 8'h12);
      host.ticks(2);
      tally_and_finish();
   end
endmodule : tb_rtc_access_and_pll_counter
